/* File: hdl/lksc_cmd_unit.sv */
// Serial command unit of an LED display / key-scan driver.
`timescale 1ns/1ps
`include "lksc_defs.svh"

module lksc_cmd_unit #(
  parameter int SUBSLOT_CYC = `LKSC_SUBSLOT_CYC,
  parameter int RAM_BYTES = 14
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic frame_select_n_i,
  input wire logic shift_clk_i,
  input wire logic shared_serial_line_i,
  output logic shared_serial_line_o,
  output logic shared_serial_line_oe_n_o,
  input wire logic key_input_a_i,
  input wire logic key_input_b_i,
  output logic [11:0] segment_out_o,
  output logic [6:0] grid_out_o,
  output logic display_on_o,
  output logic [2:0] pulse_width_o,
  output logic seven_grid_mode_o,
  output logic [3:0] data_mode_o,
  output logic [3:0] ram_addr_o
);
  import lksc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0] pins_sync; // Strobe, clock, data, key b, key a
  logic strobe_n_s; // Synchronised strobe, high = idle
  logic clk_s; // Synchronised shift clock
  logic din_s; // Synchronised serial data
  logic clk_prev_reg; // Last shift clock level for edges
  logic clk_rise; // Rising shift edge inside a frame
  logic clk_fall; // Falling shift edge inside a frame
  logic [2:0] bit_cnt_reg; // Bits of the byte in flight
  logic [7:0] shift_reg; // Receive shifter, LSB arrives first
  logic [7:0] rx_byte; // Completed byte incl. last bit
  logic byte_done; // Eighth rising edge of a byte
  lksc_phase_type phase_reg; // What the next byte means
  logic cmd_done; // A command byte completed
  logic data_done; // A display data byte completed
  logic [1:0] cmd_type; // Command group, b7..b6
  logic mode_change; // Mode command with a new mode
  logic addr_ok; // Pointer inside the display RAM
  logic [7:0] ram_reg [0:RAM_BYTES-1]; // Display RAM
  logic [5:0] rd_ptr_reg; // Key bit being shifted out
  logic [19:0] key_snap_reg; // Keys frozen at the read command
  logic oe_n_reg; // Line release, low pulls line low
  logic [2:0] digit; // Digit slot from the sequencer
  logic [3:0] subslot; // Subslot within the slot
  lksc_scan_type scan_phase; // Digit or key-source slot
  logic [3:0] key_src; // Active key source
  logic [19:0] key_state; // Latched key matrix
  logic [3:0] even_idx; // RAM byte for segments 1..8
  logic [3:0] odd_idx; // RAM byte for segments 9..12
  logic lit; // Inside the on-time of the slot
  logic [4:0] on_time; // On-time in sixteenths

  // ----------------------------------------------------------------
  // Key bit selector for the read shifter
  // ----------------------------------------------------------------
  // Byte j carries sources 2j and 2j+1, b2 and b5..b7 read zero
  function automatic logic lksc_key_bit(input logic [19:0] keys,
                                        input logic [5:0] ptr);
    logic [4:0] base;
    logic bit_val;
    base = {ptr[5:3], 2'b00};
    bit_val = 1'b0;
    case (ptr[2:0])
      3'h0: bit_val = keys[base];
      3'h1: bit_val = keys[5'(base + 5'h01)];
      3'h3: bit_val = keys[5'(base + 5'h02)];
      3'h4: bit_val = keys[5'(base + 5'h03)];
      default: bit_val = 1'b0;
    endcase
    return bit_val;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // All serial pins and key inputs come from outside this clock
  lksc_sync #(
    .WIDTH(5),
    .RESET_VAL(`LKSC_PIN_IDLE)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i({frame_select_n_i, shift_clk_i, shared_serial_line_i,
              key_input_b_i, key_input_a_i}),
    .sync_o(pins_sync)
  );

  assign strobe_n_s = pins_sync[4];
  assign clk_s = pins_sync[3];
  assign din_s = pins_sync[2];

  // ----------------------------------------------------------------
  // Shift clock edge detection
  // ----------------------------------------------------------------
  // Idle level is high so a frame does not start with a false rise
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      clk_prev_reg <= 1'b1;
    else
      clk_prev_reg <= clk_s;
  end

  // Edges only count while the strobe is low
  assign clk_rise = clk_s && !clk_prev_reg && !strobe_n_s;
  assign clk_fall = !clk_s && clk_prev_reg && !strobe_n_s;

  // ----------------------------------------------------------------
  // Byte receiver
  // ----------------------------------------------------------------
  assign rx_byte = {din_s, shift_reg[7:1]};
  assign byte_done = clk_rise && (bit_cnt_reg == 3'h7);

  // Counter restarts whenever the strobe is high
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || strobe_n_s)
      bit_cnt_reg <= 3'h0;
    else if (clk_rise)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  // Shift in from the top, so b0 ends at the bottom
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      shift_reg <= 8'h00;
    else if (clk_rise && phase_reg != PH_READ)
      shift_reg <= rx_byte;
  end

  // ----------------------------------------------------------------
  // Frame phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || strobe_n_s)
      phase_reg <= PH_COMMAND;
    else if (byte_done)
    begin
      case (phase_reg)
        PH_COMMAND:
          // First byte decides the rest of the frame
          case (rx_byte[7:6])
            `LKSC_CMD_DATA:
              if (rx_byte[`LKSC_DATA_READ_BIT])
                phase_reg <= PH_READ;
              else
                phase_reg <= PH_WRITE;
            `LKSC_CMD_ADDR:
              if (data_mode_o[`LKSC_DATA_READ_BIT])
                phase_reg <= PH_IGNORE;
              else
                phase_reg <= PH_WRITE;
            default:
              phase_reg <= PH_IGNORE;
          endcase
        PH_WRITE:
          phase_reg <= PH_WRITE;
        PH_READ:
          phase_reg <= PH_READ;
        default:
          phase_reg <= PH_IGNORE;
      endcase
    end
  end

  assign cmd_done = byte_done && (phase_reg == PH_COMMAND);
  assign data_done = byte_done && (phase_reg == PH_WRITE);
  assign cmd_type = rx_byte[7:6];

  // ----------------------------------------------------------------
  // Display mode
  // ----------------------------------------------------------------
  // Repeating the mode in force is not a change at all
  assign mode_change = cmd_done && (cmd_type == `LKSC_CMD_MODE) &&
    (rx_byte[`LKSC_MODE_SEVEN_BIT] != seven_grid_mode_o);

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      seven_grid_mode_o <= `LKSC_MODE_RESET;
    else if (mode_change)
      seven_grid_mode_o <= rx_byte[`LKSC_MODE_SEVEN_BIT];
  end

  // ----------------------------------------------------------------
  // Display control
  // ----------------------------------------------------------------
  // A mode change forces blanking until an explicit on command
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      display_on_o <= 1'b0;
    else if (cmd_done && cmd_type == `LKSC_CMD_CTRL)
      display_on_o <= rx_byte[`LKSC_CTRL_ON_BIT];
    else if (mode_change)
      display_on_o <= 1'b0;
  end

  // Width 0 is the narrowest pulse, 1/16
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      pulse_width_o <= `LKSC_WIDTH_RESET;
    else if (cmd_done && cmd_type == `LKSC_CMD_CTRL)
      pulse_width_o <= rx_byte[2:0];
  end

  // ----------------------------------------------------------------
  // Data setting
  // ----------------------------------------------------------------
  // b5..b4 are dropped, only b3..b0 are kept
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      data_mode_o <= `LKSC_DATA_RESET;
    else if (cmd_done && cmd_type == `LKSC_CMD_DATA)
      data_mode_o <= rx_byte[3:0];
  end

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  assign addr_ok = (ram_addr_o <= `LKSC_ADDR_LAST);

  // Pointer stops once outside the RAM so it cannot wrap back in
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      ram_addr_o <= `LKSC_ADDR_RESET;
    else if (cmd_done && cmd_type == `LKSC_CMD_ADDR)
      ram_addr_o <= rx_byte[3:0];
    else if (data_done && addr_ok &&
             !data_mode_o[`LKSC_DATA_FIXED_BIT])
      ram_addr_o <= ram_addr_o + 4'h1;
  end

  // ----------------------------------------------------------------
  // Display RAM
  // ----------------------------------------------------------------
  // No reset: contents are undefined until software clears them
  always_ff @(posedge sys_clk_i)
  begin
    if (data_done && addr_ok)
      ram_reg[ram_addr_o] <= rx_byte;
  end

  // ----------------------------------------------------------------
  // Key read shifter
  // ----------------------------------------------------------------
  // Snapshot keeps one read coherent if the scan latches meanwhile
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      key_snap_reg <= 20'h00000;
    else if (cmd_done && cmd_type == `LKSC_CMD_DATA)
      key_snap_reg <= key_state;
  end

  // Bits step on falling edges, wrapping after the last byte
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || phase_reg != PH_READ)
      rd_ptr_reg <= 6'h00;
    else if (clk_fall)
    begin
      if (rd_ptr_reg == `LKSC_KEY_PTR_LAST)
        rd_ptr_reg <= 6'h00;
      else
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
    end
  end

  // Open drain: pull low for a zero, release for a one
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || strobe_n_s || phase_reg != PH_READ)
      oe_n_reg <= 1'b1;
    else if (clk_fall)
      oe_n_reg <= lksc_key_bit(key_snap_reg, rd_ptr_reg);
  end

  assign shared_serial_line_o = 1'b0;
  assign shared_serial_line_oe_n_o = oe_n_reg;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  lksc_scan #(
    .SUBSLOT_CYC(SUBSLOT_CYC)
  ) u_scan (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .seven_grid_i(seven_grid_mode_o),
    .key_a_i(pins_sync[0]),
    .key_b_i(pins_sync[1]),
    .digit_o(digit),
    .subslot_o(subslot),
    .phase_o(scan_phase),
    .key_src_o(key_src),
    .key_state_o(key_state)
  );

  // ----------------------------------------------------------------
  // Segment and grid drive
  // ----------------------------------------------------------------
  assign even_idx = {digit, 1'b0};
  assign odd_idx = {digit, 1'b1};
  assign on_time = {1'b0, pulse_width_o, 1'b1}; // Width 0 gives 1/16
  assign lit = ({1'b0, subslot} < on_time);

  // Key steps own segments 1..10; the shared pin follows the mode
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      segment_out_o <= 12'h000;
      grid_out_o <= 7'h00;
    end
    else if (scan_phase == SC_KEY)
    begin
      segment_out_o <= 12'(12'h001 << key_src);
      grid_out_o <= 7'h00;
    end
    else if (display_on_o && lit)
    begin
      segment_out_o <= {ram_reg[odd_idx][3:0], ram_reg[even_idx]};
      if (seven_grid_mode_o)
        segment_out_o[11] <= 1'b0;
      grid_out_o <= 7'(7'h01 << digit);
    end
    else
    begin
      segment_out_o <= 12'h000;
      grid_out_o <= 7'h00;
    end
  end

endmodule // lksc_cmd_unit

/* File: hdl/lksc_defs.svh */
// Constants of the LED/key serial command unit: fields, resets, timing.
`ifndef LKSC_DEFS_SVH
`define LKSC_DEFS_SVH

// ----------------------------------------------------------------
// Command byte fields
// ----------------------------------------------------------------
`define LKSC_CMD_MODE 2'h0
`define LKSC_CMD_DATA 2'h1
`define LKSC_CMD_CTRL 2'h2
`define LKSC_CMD_ADDR 2'h3
`define LKSC_MODE_SEVEN_BIT 0
`define LKSC_DATA_READ_BIT 1
`define LKSC_DATA_FIXED_BIT 2
`define LKSC_CTRL_ON_BIT 3
`define LKSC_ADDR_LAST 4'hD
`define LKSC_KEY_PTR_LAST 6'h27

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LKSC_MODE_RESET 1'b1
`define LKSC_DATA_RESET 4'h0
`define LKSC_ADDR_RESET 4'h0
`define LKSC_WIDTH_RESET 3'h0
// Idle pin levels: strobe, clock, line high; keys pulled low
`define LKSC_PIN_IDLE 5'h1C

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LKSC_CLK_NS 20
`define LKSC_SUBSLOT_NS 2000
`define LKSC_SUBSLOT_CYC (`LKSC_SUBSLOT_NS / `LKSC_CLK_NS)

`endif

/* File: hdl/lksc_pkg.sv */
// Types shared by the LED/key serial command unit.
package lksc_pkg;

  // Meaning of the bytes that follow inside one strobe-low frame
  typedef enum logic [1:0] {PH_COMMAND, PH_WRITE, PH_READ, PH_IGNORE}
    lksc_phase_type;

  // Scan sequencer phase: digit drive or key-source scan
  typedef enum logic {SC_DIGIT, SC_KEY} lksc_scan_type;

endpackage

/* File: hdl/lksc_sync.sv */
// Two-flop synchroniser for pins that arrive from outside sys_clk_i.
`timescale 1ns/1ps
module lksc_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0 // Idle level of each pin
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage

  // Second stage is the only reader of the first
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      // Idle levels, so no false edge is seen on release
      meta_reg <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end

endmodule // lksc_sync

/* File: hdl/lksc_scan.sv */
// Display/key scan sequencer: digit slots, key sources, key latch.
`timescale 1ns/1ps
`include "lksc_defs.svh"
module lksc_scan #(
  parameter int SUBSLOT_CYC = `LKSC_SUBSLOT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic seven_grid_i,
  input wire logic key_a_i,
  input wire logic key_b_i,
  output logic [2:0] digit_o,
  output logic [3:0] subslot_o,
  output lksc_pkg::lksc_scan_type phase_o,
  output logic [3:0] key_src_o,
  output logic [19:0] key_state_o
);
  import lksc_pkg::*;

  logic [15:0] pre_reg; // Prescaler toward one subslot tick
  logic tick; // One-cycle enable per subslot
  logic slot_end; // Last tick of a slot
  logic [19:0] key_tmp_reg; // Samples gathered during this cycle

  // ----------------------------------------------------------------
  // Subslot enable divider
  // ----------------------------------------------------------------
  assign tick = (pre_reg == 16'(SUBSLOT_CYC - 1));
  assign slot_end = tick && (subslot_o == 4'hF);

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || tick)
      pre_reg <= 16'h0000;
    else
      pre_reg <= pre_reg + 16'h0001;
  end

  // Sixteen subslots per slot; dimming compares against this
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      subslot_o <= 4'h0;
    else if (tick)
      subslot_o <= subslot_o + 4'h1;
  end

  // ----------------------------------------------------------------
  // Slot sequence: digits, then ten key-source steps
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      phase_o <= SC_DIGIT;
      digit_o <= 3'h0;
      key_src_o <= 4'h0;
    end
    else if (slot_end)
    begin
      case (phase_o)
        SC_DIGIT:
          // Last digit depends on grid count
          // Compare with >= so a switch to six grids never overruns
          if (digit_o >= (seven_grid_i ? 3'h6 : 3'h5))
          begin
            phase_o <= SC_KEY;
            key_src_o <= 4'h0;
          end
          else
            digit_o <= digit_o + 3'h1;
        SC_KEY:
          if (key_src_o == 4'h9)
          begin
            phase_o <= SC_DIGIT;
            digit_o <= 3'h0;
          end
          else
            key_src_o <= key_src_o + 4'h1;
        default:
          phase_o <= SC_DIGIT;
      endcase
    end
  end

  // Sample both key inputs mid-step, while the source is settled
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      key_tmp_reg <= 20'h00000;
    else if (tick && phase_o == SC_KEY && subslot_o == 4'h8)
      key_tmp_reg[{key_src_o, 1'b0} +: 2] <= {key_b_i, key_a_i};
  end

  // Key store only moves at the end of a display cycle, so reads
  // never see a half-scanned matrix
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      key_state_o <= 20'h00000;
    else if (slot_end && phase_o == SC_KEY && key_src_o == 4'h9)
      key_state_o <= key_tmp_reg;
  end

endmodule // lksc_scan

/* File: verification/lksc_cmd_unit_sva.sv */
// Port-level assertion checker for the LED/key serial command unit.
`timescale 1ns/1ps
module lksc_cmd_unit_sva (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic frame_select_n_i,
  input wire logic shared_serial_line_o,
  input wire logic shared_serial_line_oe_n_o,
  input wire logic [6:0] grid_out_o,
  input wire logic display_on_o,
  input wire logic [2:0] pulse_width_o,
  input wire logic seven_grid_mode_o,
  input wire logic [3:0] data_mode_o,
  input wire logic [3:0] ram_addr_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // Single clock domain, so one clocking and one reset for all
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Open drain: the pin value itself is always the low level
  AST_OD_VALUE: assert property (
    shared_serial_line_o == 1'b0) else $error("data pin value not low");
  // Strobe high long enough means the pin is released
  AST_IDLE_RELEASE: assert property (
    frame_select_n_i [*4] |-> shared_serial_line_oe_n_o)
    else $error("data pin driven while strobe high");
  // Strobe rising ends any read within the sync latency
  AST_ABORT_RELEASE: assert property (
    $rose(frame_select_n_i) |-> ##[1:6] shared_serial_line_oe_n_o)
    else $error("data pin not released after strobe rose");
  // Outside read mode the device never pulls the line
  AST_WRITE_QUIET: assert property (
    !data_mode_o[1] |-> shared_serial_line_oe_n_o)
    else $error("data pin driven in write mode");
  // No configuration change while the link is idle
  AST_CFG_HOLD: assert property (
    frame_select_n_i [*8] |-> $stable(display_on_o) &&
      $stable(pulse_width_o) && $stable(seven_grid_mode_o) &&
      $stable(data_mode_o) && $stable(ram_addr_o))
    else $error("configuration moved while strobe high");
  // Six-grid mode leaves the shared pin as a segment
  AST_SIX_GRID: assert property (
    !seven_grid_mode_o [*3] |-> !grid_out_o[6])
    else $error("shared pin used as grid in six-grid mode");
  // Only one digit is driven at a time
  AST_GRID_ONEHOT: assert property (
    $onehot0(grid_out_o)) else $error("more than one grid active");
  // Display off means no grid drive at all
  AST_DARK_OFF: assert property (
    !display_on_o [*3] |-> grid_out_o == 7'h00)
    else $error("grid driven with display off");
  // A mode change blanks the display at once
  AST_MODE_BLANK: assert property (
    $changed(seven_grid_mode_o) |-> ##2 (grid_out_o == 7'h00) [*8])
    else $error("display not blanked after mode change");

  // ------------------------------------------------------------
  // Coverage of the main scenarios
  // ------------------------------------------------------------
  COV_ON: cover property ($rose(display_on_o));
  COV_READ: cover property ($fell(shared_serial_line_oe_n_o));
  COV_SIX: cover property ($fell(seven_grid_mode_o));
  COV_ADDR_END: cover property (ram_addr_o == 4'hE);
endmodule // lksc_cmd_unit_sva

bind lksc_cmd_unit lksc_cmd_unit_sva u_sva (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .frame_select_n_i(frame_select_n_i),
  .shared_serial_line_o(shared_serial_line_o),
  .shared_serial_line_oe_n_o(shared_serial_line_oe_n_o),
  .grid_out_o(grid_out_o),
  .display_on_o(display_on_o),
  .pulse_width_o(pulse_width_o),
  .seven_grid_mode_o(seven_grid_mode_o),
  .data_mode_o(data_mode_o),
  .ram_addr_o(ram_addr_o)
);

/* File: verification/lksc_host_model.sv */
// Behavioural host driving the strobed three-wire serial link.
`timescale 1ns/1ps
module lksc_host_model (
  input wire logic sys_clk_i,
  input wire logic line_i,
  output logic frame_select_n_o,
  output logic shift_clk_o,
  output logic drive_en_o,
  output logic drive_bit_o
);
  // Idle: strobe high, clock high, line left to the pull-up
  initial
  begin
    frame_select_n_o = 1'b1;
    shift_clk_o = 1'b1;
    drive_en_o = 1'b0;
    drive_bit_o = 1'b0;
  end

  // Every change lands just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  // Strobe falls; the next byte is the command
  task automatic frame_begin();
    tick(1);
    frame_select_n_o = 1'b0;
    tick(4);
  endtask

  // Strobe rises after the last rising clock edge
  task automatic frame_end();
    tick(4);
    frame_select_n_o = 1'b1;
    drive_en_o = 1'b0;
    tick(8);
  endtask

  // 160 ns link period, 5 low and 3 high system cycles
  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      shift_clk_o = 1'b0;
      drive_en_o = 1'b1;
      drive_bit_o = b[i];
      tick(5);
      shift_clk_o = 1'b1;
      tick(3);
    end
  endtask

  // Line released; bit captured as the clock rises
  task automatic get_byte(output logic [7:0] b);
    drive_en_o = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      shift_clk_o = 1'b0;
      tick(5);
      b[i] = line_i;
      shift_clk_o = 1'b1;
      tick(3);
    end
  endtask
endmodule // lksc_host_model

/* File: verification/lksc_cmd_unit_tb.sv */
// Self-checking testbench of the LED/key serial command unit.
`timescale 1ns/1ps
module lksc_cmd_unit_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic srst;
  logic key_a, key_b; // Driven by the key matrix model below
  logic key_en = 1'b0; // Keys follow chosen sources when set
  logic fsel_n, sclk, h_en, h_bit, line, ser_o, oe_n, on, seven;
  logic [11:0] seg;
  logic [6:0] grid;
  logic [2:0] width;
  logic [3:0] dmode, addr;
  logic [7:0] kb;
  logic [7:0] kexp [6] = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h08, 8'h02};
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;
  logic seen;

  // Open-drain wire with pull-up: any party may pull it low
  assign line = !((h_en && !h_bit) || (!oe_n && !ser_o));

  always #10 sys_clk = ~sys_clk;

  lksc_cmd_unit #(.SUBSLOT_CYC(2)) u_dut (
    .sys_clk_i(sys_clk), .srst_i(srst), .frame_select_n_i(fsel_n),
    .shift_clk_i(sclk), .shared_serial_line_i(line),
    .shared_serial_line_o(ser_o), .shared_serial_line_oe_n_o(oe_n),
    .key_input_a_i(key_a), .key_input_b_i(key_b), .segment_out_o(seg),
    .grid_out_o(grid), .display_on_o(on), .pulse_width_o(width),
    .seven_grid_mode_o(seven), .data_mode_o(dmode), .ram_addr_o(addr)
  );

  lksc_host_model u_host (
    .sys_clk_i(sys_clk), .line_i(line), .frame_select_n_o(fsel_n),
    .shift_clk_o(sclk), .drive_en_o(h_en), .drive_bit_o(h_bit)
  );

  // Key a pressed on source 10, key b on source 1
  always @(posedge sys_clk)
  begin
    #1;
    key_a = key_en & seg[9];
    key_b = key_en & seg[0];
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One-byte command frame
  task automatic cmd(input logic [7:0] c);
    u_host.frame_begin();
    u_host.put_bits(c, 8);
    u_host.frame_end();
  endtask

  // Address command then n data bytes; bytes past the third repeat d2
  task automatic wr(input logic [3:0] a, input logic [7:0] d0,
                    input logic [7:0] d1, input logic [7:0] d2, input int n);
    u_host.frame_begin();
    u_host.put_bits({4'hC, a}, 8);
    for (int i = 0; i < n; i++)
      u_host.put_bits(i == 0 ? d0 : (i == 1 ? d1 : d2), 8);
    u_host.frame_end();
  endtask

  // Wait for digit one lit, bounded by one scan cycle and more
  task automatic digit_one(input logic [11:0] exp);
    k = 0;
    while (!(grid === 7'h01 && seg !== 12'h000) && k < 1200)
    begin
      u_host.tick(1);
      k++;
    end
    chk(seg, exp, "digit one segments");
  endtask

  task automatic tally_and_finish();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    u_host.tick(4);
    chk(seven, 1'b1, "power-on mode");
    chk(dmode, 4'h0, "power-on data mode");
    chk(addr, 4'h0, "power-on address");
    chk({on, width}, 4'h0, "power-on display");
    chk(oe_n, 1'b1, "pin released");
    u_host.put_bits(8'h8F, 8);
    chk(on, 1'b0, "clocks with strobe high");
    cmd(8'h8F);
    chk({on, width}, 4'hF, "display on width 7");
    cmd(8'h80);
    chk({on, width}, 4'h0, "control 80");
    cmd(8'h8B);
    chk({on, width}, 4'hB, "display on width 3");
    u_host.frame_begin();
    u_host.put_bits(8'h80, 3);
    u_host.frame_end();
    chk(on, 1'b1, "partial byte dropped");
    cmd(8'h89);
    chk({on, width}, 4'h9, "byte after abort aligned");
    cmd(8'h01);
    chk(on, 1'b1, "same mode no effect");
    cmd(8'h3C);
    chk(seven, 1'b0, "six-grid mode");
    for (int i = 0; i < 20; i++)
    begin
      u_host.tick(15);
      chk(grid, 7'h00, "blank after mode change");
    end
    cmd(8'h01);
    cmd(8'h8F);
    seen = 1'b0;
    for (int i = 0; i < 700; i++)
    begin
      u_host.tick(1);
      seen = seen | (grid[6] === 1'b1);
    end
    chk(seen, 1'b1, "seventh grid driven");
    cmd(8'h72);
    chk(dmode, 4'h2, "read data mode");
    cmd(8'h40);
    chk(dmode, 4'h0, "write data mode");
    wr(4'h0, 8'h00, 8'h00, 8'h00, 14);
    chk(addr, 4'hE, "address after clear");
    wr(4'h0, 8'hA5, 8'h04, 8'h11, 3);
    chk(addr, 4'h3, "address after three bytes");
    digit_one(12'h4A5);
    wr(4'hE, 8'hFF, 8'hFF, 8'hFF, 1);
    chk(addr, 4'hE, "out-of-range address");
    digit_one(12'h4A5);
    cmd(8'h44);
    chk(dmode, 4'h4, "fixed address data mode");
    wr(4'h2, 8'h11, 8'h22, 8'h33, 3);
    chk(addr, 4'h2, "fixed address holds");
    key_en = 1'b1;
    u_host.tick(1200);
    u_host.frame_begin();
    u_host.put_bits(8'h42, 8);
    u_host.tick(50);
    for (int i = 0; i < 6; i++)
    begin
      u_host.get_byte(kb);
      chk(kb, kexp[i], "key byte");
    end
    u_host.frame_end();
    chk(oe_n, 1'b1, "pin released after read");
    tally_and_finish();
  end
endmodule // lksc_cmd_unit_tb
